// ===== tcpwm_consts.svh
`ifndef TCPWM_CONSTS_SVH
`define TCPWM_CONSTS_SVH

// Register byte offsets.
`define TCPWM_CTRL_OFS 8'h00
`define TCPWM_PERIOD_OFS 8'h04
`define TCPWM_COMPARE_OFS 8'h08
`define TCPWM_COUNT_OFS 8'h0C
`define TCPWM_CAPTURE_OFS 8'h10
`define TCPWM_STATUS_OFS 8'h14
`define TCPWM_MASK_OFS 8'h18
`define TCPWM_DEADBAND_OFS 8'h1C

// Control fields.
`define TCPWM_CTRL_EN 0
`define TCPWM_CTRL_MODE_LO 1
`define TCPWM_CTRL_MODE_HI 2
`define TCPWM_CTRL_REL_LO 3
`define TCPWM_CTRL_REL_HI 5
`define TCPWM_CTRL_CLK_LO 6
`define TCPWM_CTRL_CLK_HI 7
`define TCPWM_CTRL_RESET 32'h0000_0000

// Status bits.
`define TCPWM_ST_TC 0
`define TCPWM_ST_CMP 1
`define TCPWM_ST_CAP 2

`define TCPWM_PERIOD_RESET 16'hFFFF
`define TCPWM_RESP_OKAY 2'h0
`define TCPWM_RESP_SLVERR 2'h2
`endif

// ===== tcpwm_pkg.sv
package tcpwm_pkg;
   typedef enum logic [1:0] {
      mode_free,
      mode_one_shot,
      mode_gated
   } tcpwm_mode_t;
   typedef enum logic [2:0] {
      cmp_less,
      cmp_less_equal,
      cmp_equal,
      cmp_greater_equal,
      cmp_greater
   } tcpwm_rel_t;
endpackage : tcpwm_pkg

// ===== tcpwm_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for one routed input.
module tcpwm_sync (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Data
   input wire logic din,
   output logic dout
);
   logic stage1;
   logic next_stage1;
   logic next_dout;

   always_comb begin
      next_stage1 = din;
      next_dout = stage1;
      if (!aresetn) begin
         next_stage1 = 1'b0;
         next_dout = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      stage1 <= next_stage1;
      dout <= next_dout;
   end
endmodule : tcpwm_sync

// ===== tcpwm_top.sv
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`include "tcpwm_consts.svh"
module tcpwm_top #(
   parameter int WIDTH = 16,
   parameter int DB_WIDTH = 8,
   parameter int NUM_CLK = 4
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Routed inputs
   input wire logic [NUM_CLK-1:0] clk_src,
   input wire logic enable_in,
   input wire logic reset_in,
   input wire logic capture_in,
   input wire logic kill_in,
   // Routed outputs
   output logic cmp_out,
   output logic cmp_n_out,
   output logic tc_out,
   output logic irq
);
   if (WIDTH != 16 || DB_WIDTH < 1 || DB_WIDTH > 16 ||
       NUM_CLK < 1 || NUM_CLK > 4) begin : g_bad_params
      $error("tcpwm_top: unsupported parameter values.");
   end

   // Every routed input is synchronised before use.
   localparam int NIN = NUM_CLK + 4;
   logic [NIN-1:0] raw_in;
   logic [NIN-1:0] sync_in;
   assign raw_in = {kill_in, capture_in, reset_in, enable_in, clk_src};
   for (genvar g = 0; g < NIN; g++) begin : g_sync
      tcpwm_sync u_sync (
         .aclk(aclk),
         .aresetn(aresetn),
         .din(raw_in[g]),
         .dout(sync_in[g])
      );
   end
   logic [NUM_CLK-1:0] clk_s;
   logic en_s, rst_s, cap_s, kill_s;
   assign clk_s = sync_in[NUM_CLK-1:0];
   assign en_s = sync_in[NUM_CLK];
   assign rst_s = sync_in[NUM_CLK+1];
   assign cap_s = sync_in[NUM_CLK+2];
   assign kill_s = sync_in[NUM_CLK+3];

   // Registers and state.
   logic [31:0] ctrl, next_ctrl;
   logic [WIDTH-1:0] period, next_period;
   logic [WIDTH-1:0] compare, next_compare;
   logic [WIDTH-1:0] count, next_count;
   logic [WIDTH-1:0] capture, next_capture;
   logic [2:0] status, next_status;
   logic [2:0] mask, next_mask;
   logic [DB_WIDTH-1:0] deadband, next_deadband;
   logic [DB_WIDTH-1:0] db_cnt, next_db_cnt;
   logic running, next_running;
   logic [NUM_CLK-1:0] clk_d, next_clk_d;
   logic cap_d, next_cap_d;
   logic en_d, next_en_d;
   logic pwm_d, next_pwm_d;
   logic next_cmp_out, next_cmp_n_out, next_tc_out, next_irq;
   // Bus state.
   logic aw_held, next_aw_held, w_held, next_w_held;
   logic [7:0] aw_addr, next_aw_addr;
   logic [31:0] w_data, next_w_data;
   logic [3:0] w_strb, next_w_strb;
   logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
   logic [1:0] next_bresp, next_rresp;
   logic [31:0] next_rdata;

   // Combinational helpers.
   tcpwm_pkg::tcpwm_mode_t mode;
   tcpwm_pkg::tcpwm_rel_t rel;
   logic [1:0] clk_sel;
   logic tick, cmp_true, tc_ev, cap_ev, start_ev, wr_fire, rd_fire;
   logic [31:0] wmask, rd_word;
   logic rd_ok, wr_ok;

   assign mode = tcpwm_pkg::tcpwm_mode_t'(
      ctrl[`TCPWM_CTRL_MODE_HI:`TCPWM_CTRL_MODE_LO]);
   assign rel = tcpwm_pkg::tcpwm_rel_t'(
      ctrl[`TCPWM_CTRL_REL_HI:`TCPWM_CTRL_REL_LO]);
   assign clk_sel = ctrl[`TCPWM_CTRL_CLK_HI:`TCPWM_CTRL_CLK_LO];
   // Rising edge of the chosen source clocks the counter.
   assign tick = (32'(clk_sel) < NUM_CLK) &&
                 clk_s[clk_sel] && !clk_d[clk_sel];
   assign cap_ev = cap_s && !cap_d;
   // Start on a rising enable bit, not its level, so a spent one-shot stays halted until reset_in or a new enable.
   assign start_ev = ctrl[`TCPWM_CTRL_EN] && !en_d;
   assign wr_fire = aw_held && w_held && !s_axi_bvalid;
   assign rd_fire = s_axi_arvalid && s_axi_arready;
   assign wmask = {{8{w_strb[3]}}, {8{w_strb[2]}},
                   {8{w_strb[1]}}, {8{w_strb[0]}}};

   always_comb begin
      cmp_true = 1'b0;
      unique case (rel)
         tcpwm_pkg::cmp_less: cmp_true = count < compare;
         tcpwm_pkg::cmp_less_equal: cmp_true = count <= compare;
         tcpwm_pkg::cmp_equal: cmp_true = count == compare;
         tcpwm_pkg::cmp_greater_equal: cmp_true = count >= compare;
         tcpwm_pkg::cmp_greater: cmp_true = count > compare;
         default: cmp_true = 1'b0;
      endcase
   end

   // Counter, capture and PWM outputs.
   always_comb begin
      next_count = count;
      next_running = running;
      next_capture = capture;
      next_tc_out = 1'b0;
      tc_ev = 1'b0;
      next_clk_d = clk_s;
      next_cap_d = cap_s;
      next_en_d = ctrl[`TCPWM_CTRL_EN];
      next_pwm_d = pwm_d;
      next_db_cnt = db_cnt;
      next_cmp_out = cmp_out;
      next_cmp_n_out = cmp_n_out;
      if (!ctrl[`TCPWM_CTRL_EN]) begin
         next_running = 1'b0;
      end else if (start_ev || rst_s) begin
         next_count = period;
         next_running = 1'b1;
      end else if (running && tick &&
                   (mode != tcpwm_pkg::mode_gated || en_s)) begin
         if (count == '0) begin
            next_count = period;
            tc_ev = 1'b1;
            next_tc_out = 1'b1;
            if (mode == tcpwm_pkg::mode_one_shot)
               next_running = 1'b0;
         end else begin
            next_count = count - 1'b1;
         end
      end
      if (cap_ev)
         next_capture = count;
      // Deadband: both outputs idle for deadband ticks after each edge.
      if (tick && db_cnt != '0)
         next_db_cnt = db_cnt - 1'b1;
      if (cmp_true != pwm_d) begin
         next_pwm_d = cmp_true;
         next_db_cnt = deadband;
         next_cmp_out = 1'b0;
         next_cmp_n_out = 1'b0;
      end else if (db_cnt == '0) begin
         next_cmp_out = pwm_d;
         next_cmp_n_out = !pwm_d;
      end
      if (kill_s || !ctrl[`TCPWM_CTRL_EN]) begin
         next_cmp_out = 1'b0;
         next_cmp_n_out = 1'b0;
      end
      if (!aresetn) begin
         next_count = '0;
         next_running = 1'b0;
         next_capture = '0;
         next_tc_out = 1'b0;
         next_clk_d = '0;
         next_cap_d = 1'b0;
         next_en_d = 1'b0;
         next_pwm_d = 1'b0;
         next_db_cnt = '0;
         next_cmp_out = 1'b0;
         next_cmp_n_out = 1'b0;
      end
   end

   // Register file and AXI4-Lite slave.
   always_comb begin
      rd_ok = 1'b1;
      unique case (s_axi_araddr)
         `TCPWM_CTRL_OFS: rd_word = ctrl;
         `TCPWM_PERIOD_OFS: rd_word = 32'(period);
         `TCPWM_COMPARE_OFS: rd_word = 32'(compare);
         `TCPWM_COUNT_OFS: rd_word = 32'(count);
         `TCPWM_CAPTURE_OFS: rd_word = 32'(capture);
         `TCPWM_STATUS_OFS: rd_word = 32'(status);
         `TCPWM_MASK_OFS: rd_word = 32'(mask);
         `TCPWM_DEADBAND_OFS: rd_word = 32'(deadband);
         default: begin
            rd_word = 32'h0000_0000;
            rd_ok = 1'b0;
         end
      endcase
   end

   always_comb begin
      next_ctrl = ctrl;
      next_period = period;
      next_compare = compare;
      next_mask = mask;
      next_deadband = deadband;
      next_status = status;
      wr_ok = 1'b1;
      next_aw_held = aw_held;
      next_aw_addr = aw_addr;
      next_w_held = w_held;
      next_w_data = w_data;
      next_w_strb = w_strb;
      next_awready = !aw_held && !s_axi_awready;
      next_wready = !w_held && !s_axi_wready;
      next_bvalid = s_axi_bvalid;
      next_bresp = s_axi_bresp;
      next_arready = 1'b0;
      next_rvalid = s_axi_rvalid;
      next_rdata = s_axi_rdata;
      next_rresp = s_axi_rresp;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
         next_awready = 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
         next_wready = 1'b0;
      end
      if (wr_fire) begin
         unique case (aw_addr)
            `TCPWM_CTRL_OFS: next_ctrl = (ctrl & ~wmask) | (w_data & wmask);
            `TCPWM_PERIOD_OFS: next_period =
               WIDTH'((period & ~wmask) | (w_data & wmask));
            `TCPWM_COMPARE_OFS: next_compare =
               WIDTH'((compare & ~wmask) | (w_data & wmask));
            `TCPWM_MASK_OFS: next_mask = 3'((mask & ~wmask) | (w_data & wmask));
            `TCPWM_DEADBAND_OFS: next_deadband =
               DB_WIDTH'((deadband & ~wmask) | (w_data & wmask));
            `TCPWM_STATUS_OFS: next_status = status & ~3'(w_data & wmask);
            `TCPWM_COUNT_OFS, `TCPWM_CAPTURE_OFS: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
         endcase
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = wr_ok ? `TCPWM_RESP_OKAY : `TCPWM_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      // Events set sticky bits after any clear, so a set wins.
      if (tc_ev) next_status[`TCPWM_ST_TC] = 1'b1;
      if (cmp_true && !pwm_d) next_status[`TCPWM_ST_CMP] = 1'b1;
      if (cap_ev) next_status[`TCPWM_ST_CAP] = 1'b1;
      if (!s_axi_rvalid && !s_axi_arready && s_axi_arvalid)
         next_arready = 1'b1;
      if (rd_fire) begin
         next_rvalid = 1'b1;
         next_rdata = rd_word;
         next_rresp = rd_ok ? `TCPWM_RESP_OKAY : `TCPWM_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
      next_irq = |(next_status & mask);
      if (!aresetn) begin
         next_ctrl = `TCPWM_CTRL_RESET;
         next_period = `TCPWM_PERIOD_RESET;
         next_compare = '0;
         next_mask = '0;
         next_deadband = '0;
         next_status = '0;
         next_aw_held = 1'b0;
         next_aw_addr = '0;
         next_w_held = 1'b0;
         next_w_data = '0;
         next_w_strb = '0;
         next_awready = 1'b0;
         next_wready = 1'b0;
         next_bvalid = 1'b0;
         next_bresp = `TCPWM_RESP_OKAY;
         next_arready = 1'b0;
         next_rvalid = 1'b0;
         next_rdata = '0;
         next_rresp = `TCPWM_RESP_OKAY;
         next_irq = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      ctrl <= next_ctrl;
      period <= next_period;
      compare <= next_compare;
      count <= next_count;
      capture <= next_capture;
      status <= next_status;
      mask <= next_mask;
      deadband <= next_deadband;
      db_cnt <= next_db_cnt;
      running <= next_running;
      clk_d <= next_clk_d;
      cap_d <= next_cap_d;
      en_d <= next_en_d;
      pwm_d <= next_pwm_d;
      cmp_out <= next_cmp_out;
      cmp_n_out <= next_cmp_n_out;
      tc_out <= next_tc_out;
      irq <= next_irq;
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
   end
endmodule : tcpwm_top

// ===== tcpwm_monitor.sv
`timescale 1ns/1ps
module tcpwm_monitor (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   // Routed signals
   input wire logic kill_in,
   input wire logic cmp_out,
   input wire logic cmp_n_out,
   input wire logic tc_out
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Two sync stages plus the output register give kill three cycles.
   a_kill_forces_low: assert property (kill_in [*4] |->
      !cmp_out && !cmp_n_out) else $error("kill left an output high");
   a_never_both_high: assert property (!(cmp_out && cmp_n_out))
      else $error("both compare outputs high");
   a_no_joint_edge: assert property (
      !($changed(cmp_out) && $changed(cmp_n_out)))
      else $error("compare outputs changed together");
   a_deadband_gap: assert property ($fell(cmp_out) |->
      !cmp_n_out [*4]) else $error("no deadband after compare edge");
   // The fastest source ticks every 8 cycles, so pulses are far apart.
   a_tc_single_pulse: assert property (tc_out |=>
      !tc_out [*7]) else $error("terminal count pulse too long");
   a_write_answers: assert property (s_axi_wvalid && s_axi_wready
      |-> ##[1:8] s_axi_bvalid) else $error("write not answered");
   a_read_answers: assert property (s_axi_arvalid && s_axi_arready
      |-> ##[1:2] s_axi_rvalid) else $error("read not answered");
   a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready &&
      s_axi_araddr[7:5] != 3'h0 |-> ##[1:2] s_axi_rvalid &&
      s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   c_tc: cover property (tc_out);
   c_kill: cover property (kill_in ##1 !cmp_out);
   c_comp: cover property ($rose(cmp_n_out));
endmodule : tcpwm_monitor
bind tcpwm_top tcpwm_monitor u_mon (.*);

// ===== tcpwm_fabric.sv
`timescale 1ns/1ps
module tcpwm_fabric (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Requests from the bench
   input wire logic [3:0] req,
   // Routed signals
   output logic [3:0] clk_src,
   output logic enable_in,
   output logic reset_in,
   output logic capture_in,
   output logic kill_in
);
   logic [7:0] div;
   logic [3:0] sig;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div <= 8'h00;
         sig <= 4'h0;
      end else begin
         div <= div + 8'h01;
         sig <= req;
      end
   end
   // Sources stay well below half the bus clock so no edge is lost.
   assign clk_src = div[5:2];
   assign {kill_in, capture_in, reset_in, enable_in} = sig;
endmodule : tcpwm_fabric

// ===== tcpwm_tb_top.sv
`timescale 1ns/1ps
`include "tcpwm_consts.svh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin failures++; \
   $display("wrong value at %0t: %h vs %h", $time, (a), (e)); end end
module tcpwm_tb_top;
   logic aclk, aresetn;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rv, rw, lfsr;
   logic [3:0] s_axi_wstrb, clk_src, req;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   logic enable_in, reset_in, capture_in, kill_in;
   logic cmp_out, cmp_n_out, tc_out, irq;
   logic [65:0] exp_q[$];
   logic [1:0] bq[$];
   logic [65:0] e;
   int failures = 0;
   int tests_run = 0;
   int n, k;
   tcpwm_top dut (.*);
   tcpwm_fabric fab (.*);
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   // Responses are judged here against the notes left by the drivers.
   always @(posedge aclk) begin
      if (s_axi_rvalid && s_axi_rready) begin
         e = exp_q.pop_front();
         `CHK(s_axi_rdata & e[63:32], e[31:0])
         `CHK(s_axi_rresp, e[65:64])
      end
      if (s_axi_bvalid && s_axi_bready)
         `CHK(s_axi_bresp, bq.pop_front())
   end
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : nxt
   task automatic report_and_stop;
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop
   task automatic tick(input int lim);
      @(posedge aclk);
      n++;
      if (n > lim) begin
         failures++;
         report_and_stop();
      end
   endtask : tick
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r = 2'h0);
      bq.push_back(r);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      n = 0;
      do begin
         tick(100);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] x,
                     input logic [31:0] m = 32'hFFFF_FFFF,
                     input logic [1:0] r = 2'h0);
      exp_q.push_back({r, m, x});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      n = 0;
      do begin
         tick(100);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rv = s_axi_rdata;
   endtask : rd
   task automatic wait_tc;
      n = 0;
      do tick(3000); while (!tc_out);
   endtask : wait_tc
   task automatic restart(input logic [31:0] c);
      wr(`TCPWM_CTRL_OFS, 32'h0);
      wr(`TCPWM_STATUS_OFS, 32'h7);
      wr(`TCPWM_CTRL_OFS, c);
   endtask : restart
   initial begin
      aresetn = 1'b0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
      s_axi_wstrb = 4'hF;
      s_axi_bready = 1'b1;
      s_axi_rready = 1'b1;
      req = 4'h0;
      lfsr = 32'h0F441287;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(`TCPWM_CTRL_OFS, `TCPWM_CTRL_RESET);
      rd(`TCPWM_PERIOD_OFS, 32'h0000_FFFF);
      rd(8'h20, 32'h0, 32'hFFFF_FFFF, `TCPWM_RESP_SLVERR);
      wr(8'h24, 32'h1, `TCPWM_RESP_SLVERR);
      repeat (4) begin
         lfsr = nxt(lfsr);
         wr(`TCPWM_PERIOD_OFS, lfsr);
         rd(`TCPWM_PERIOD_OFS, {16'h0, lfsr[15:0]});
         wr(`TCPWM_MASK_OFS, lfsr);
         rd(`TCPWM_MASK_OFS, {29'h0, lfsr[2:0]});
      end
      wr(`TCPWM_DEADBAND_OFS, 32'h2);
      wr(`TCPWM_PERIOD_OFS, 32'h14);
      wr(`TCPWM_COMPARE_OFS, 32'hA);
      wr(`TCPWM_MASK_OFS, 32'h1);
      restart(32'h3);
      wait_tc();
      repeat (4) @(posedge aclk);
      `CHK(irq, 1'b1)
      k = 0;
      repeat (400) begin
         @(posedge aclk);
         if (tc_out) k++;
      end
      `CHK(k, 0)
      rd(`TCPWM_COUNT_OFS, 32'h14);
      rd(`TCPWM_STATUS_OFS, 32'h1, 32'h1);
      wr(`TCPWM_STATUS_OFS, 32'h7);
      rd(`TCPWM_STATUS_OFS, 32'h0, 32'h7);
      `CHK(irq, 1'b0)
      repeat (50) @(posedge aclk);
      rd(`TCPWM_COUNT_OFS, 32'h14);
      for (int i = 0; i < 5; i++) begin
         restart(32'h1 | (i << 3));
         wait_tc();
         wait_tc();
         rd(`TCPWM_STATUS_OFS, 32'h2, 32'h2);
      end
      // Gated mode with the gate low must leave the fresh period alone.
      restart(32'h5);
      repeat (50) @(posedge aclk);
      rd(`TCPWM_COUNT_OFS, 32'h14);
      req <= 4'h1;
      repeat (100) @(posedge aclk);
      rd(`TCPWM_COUNT_OFS, 32'h0, 32'h0);
      `CHK(rv < 32'h14, 1'b1)
      req <= 4'h3;
      repeat (20) @(posedge aclk);
      rd(`TCPWM_COUNT_OFS, 32'h14);
      req <= 4'h0;
      restart(32'hC1);
      repeat (100) @(posedge aclk);
      rd(`TCPWM_COUNT_OFS, 32'h0, 32'h0);
      rw = rv;
      repeat (130) @(posedge aclk);
      rd(`TCPWM_COUNT_OFS, 32'h0, 32'h0);
      `CHK((rw + 32'h15 - rv) % 32'h15 inside {[1:3]}, 1'b1)
      req <= 4'h4;
      repeat (6) @(posedge aclk);
      req <= 4'h0;
      rd(`TCPWM_CAPTURE_OFS, 32'h0, 32'h0);
      `CHK(rv <= 32'h14, 1'b1)
      rd(`TCPWM_STATUS_OFS, 32'h4, 32'h4);
      restart(32'h1);
      repeat (60) @(posedge aclk);
      req <= 4'h8;
      repeat (40) @(posedge aclk);
      `CHK(cmp_out | cmp_n_out, 1'b0)
      req <= 4'h0;
      k = 0;
      rw = 32'h0;
      repeat (300) begin
         @(posedge aclk);
         if (cmp_out) k++;
         if (cmp_n_out) rw++;
      end
      `CHK(k != 0 && rw != 0, 1'b1)
      `CHK(exp_q.size(), 0)
      report_and_stop();
   end
endmodule : tcpwm_tb_top
